// ===== rtl/nvm_host_pkg.sv
package nvm_host_pkg;

	// ****************************************
	// Device register indices, reached by vendor set/get test requests
	// ****************************************
	localparam logic [7:0] DEV_CONFIG_IDX = 8'h4C;
	localparam logic [7:0] DEV_ADDR_IDX   = 8'h4D;
	localparam logic [7:0] DEV_VALUE_IDX  = 8'h4E;
	localparam logic [7:0] DEV_CTRL_IDX   = 8'h4F;
	localparam logic [7:0] DEV_STATUS_IDX = 8'h50;

	// Bit positions inside device registers
	localparam int CFG_ENABLE_BIT = 0;
	localparam int CTRL_LAUNCH_BIT = 0;
	localparam int STATUS_OK_BIT = 0;
	localparam logic [7:0] CFG_ENABLE_MASK = 8'h01;
	localparam logic [7:0] CTRL_LAUNCH_MASK = 8'h01;

	// Programmable location window and retry budget
	localparam logic [7:0] NVM_LOW_ADDR  = 8'h80;
	localparam logic [7:0] NVM_HIGH_ADDR = 8'hFE;
	localparam logic [3:0] MAX_RETRIES   = 4'hA;

	// ****************************************
	// Own APB register map
	// ****************************************
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_ADDR   = 12'h004;
	localparam logic [11:0] REG_DATA   = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00C;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_SKIP_BIT  = 1;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic       SKIP_RESET = 1'b0;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  index;
		logic [7:0]  value;
	} vreq_type;

	typedef struct packed {
		logic        done;
		logic [7:0]  data;
	} vrsp_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_type;

	typedef struct packed {
		logic        start;
		logic        skip_zero;
		logic [7:0]  addr;
		logic [7:0]  data;
	} cmd_type;

	// Packed so that zero extension gives the status word
	typedef struct packed {
		logic [3:0]  retries;
		logic        skipped;
		logic        range_err;
		logic        defective;
		logic        ok;
		logic        done;
		logic        busy;
	} stat_type;

endpackage

// ===== rtl/nvm_cmd_regs.sv
`timescale 1ns/10ps

module nvm_cmd_regs (
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rstn,
	// APB slave
	input  wire nvm_host_pkg::apb_req_type apb_req,
	output nvm_host_pkg::apb_rsp_type      apb_rsp,
	// Engine side
	input  wire nvm_host_pkg::stat_type    stat,
	output nvm_host_pkg::cmd_type          cmd
);

	typedef struct packed {
		nvm_host_pkg::cmd_type cmd;
		logic [31:0]           rdata;
	} regs_type;

	regs_type regs_ff;
	regs_type nxt_regs;
	logic     setup;
	logic     access;
	logic     mapped;

	assign setup  = apb_req.psel && !apb_req.penable;
	assign access = apb_req.psel && apb_req.penable;
	assign mapped = (apb_req.paddr == nvm_host_pkg::REG_CTRL) || (apb_req.paddr == nvm_host_pkg::REG_ADDR) ||
		(apb_req.paddr == nvm_host_pkg::REG_DATA) || (apb_req.paddr == nvm_host_pkg::REG_STATUS);

	always_comb begin
		nxt_regs = regs_ff;
		nxt_regs.cmd.start = 1'b0;
		// Read data is caught in the setup cycle so that it leaves a flop with no wait state
		if (setup) begin
			unique case (apb_req.paddr)
				nvm_host_pkg::REG_CTRL:   nxt_regs.rdata = {30'h0, regs_ff.cmd.skip_zero, 1'b0};
				nvm_host_pkg::REG_ADDR:   nxt_regs.rdata = {24'h0, regs_ff.cmd.addr};
				nvm_host_pkg::REG_DATA:   nxt_regs.rdata = {24'h0, regs_ff.cmd.data};
				nvm_host_pkg::REG_STATUS: nxt_regs.rdata = {22'h0, stat};
				default:                  nxt_regs.rdata = 32'h0;
			endcase
		end
		// Operands are frozen while a write is running
		if (access && apb_req.pwrite && !stat.busy) begin
			unique case (apb_req.paddr)
				nvm_host_pkg::REG_CTRL: begin
					nxt_regs.cmd.start = apb_req.pwdata[nvm_host_pkg::CTRL_START_BIT];
					nxt_regs.cmd.skip_zero = apb_req.pwdata[nvm_host_pkg::CTRL_SKIP_BIT];
				end
				nvm_host_pkg::REG_ADDR: nxt_regs.cmd.addr = apb_req.pwdata[7:0];
				nvm_host_pkg::REG_DATA: nxt_regs.cmd.data = apb_req.pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			regs_ff <= '{cmd: '{start: 1'b0, skip_zero: nvm_host_pkg::SKIP_RESET,
				addr: nvm_host_pkg::ADDR_RESET, data: nvm_host_pkg::DATA_RESET}, rdata: 32'h0};
		end else begin
			regs_ff <= nxt_regs;
		end
	end

	assign cmd = regs_ff.cmd;
	assign apb_rsp = '{prdata: regs_ff.rdata, pready: 1'b1, pslverr: access && !mapped};

endmodule

// ===== rtl/nvm_write_host.sv
`timescale 1ns/10ps

// Overview of operation
// - Optionally skip writing all-zero values
// - Only target addresses 0x80 through 0xFE
// - Reach device only through vendor test requests
// - Set memory enable before any write
// - Load target address into address register
// - Then load value into data register
// - Set launch bit to start programming
// - Poll launch bit until it clears
// - Then read write-success status bit
// - On success finish, next byte needs no enable
// - On failure relaunch, give up after ten
module nvm_write_host (
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rstn,
	// Software register bus
	input  wire nvm_host_pkg::apb_req_type apb_req,
	output nvm_host_pkg::apb_rsp_type      apb_rsp,
	// Vendor set/get test request port toward the device
	output nvm_host_pkg::vreq_type         vreq,
	input  wire nvm_host_pkg::vrsp_type    vrsp
);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_ENABLE = 7'h02,
		ST_ADDR   = 7'h04,
		ST_DATA   = 7'h08,
		ST_LAUNCH = 7'h10,
		ST_POLL   = 7'h20,
		ST_STATUS = 7'h40
	} phase_type;

	typedef struct packed {
		phase_type               phase;
		nvm_host_pkg::vreq_type  req;
		logic                    enabled;
		logic [7:0]              addr;
		logic [7:0]              data;
		nvm_host_pkg::stat_type  stat;
	} host_type;

	localparam host_type HOST_RESET = '{
		phase:   ST_IDLE,
		req:     '0,
		enabled: 1'b0,
		addr:    8'h00,
		data:    8'h00,
		stat:    '0
	};

	host_type              host_ff;
	host_type              nxt_host;
	nvm_host_pkg::cmd_type cmd;
	logic                  taken;
	logic                  in_range;
	logic                  launch_busy;
	logic                  write_ok;

	// ****************************************
	// Software registers
	// ****************************************
	nvm_cmd_regs u_regs (
		.core_clk (core_clk),
		.rstn     (rstn),
		.apb_req  (apb_req),
		.apb_rsp  (apb_rsp),
		.stat     (host_ff.stat),
		.cmd      (cmd)
	);

	// ****************************************
	// Request builder
	// ****************************************
	function automatic nvm_host_pkg::vreq_type dev_req(
		input logic       wr,
		input logic [7:0] idx,
		input logic [7:0] val
	);
		nvm_host_pkg::vreq_type r;
		r.valid = 1'b1;
		r.write = wr;
		r.index = idx;
		r.value = val;
		return r;
	endfunction

	// A request is consumed on the edge where the device answers
	assign taken = host_ff.req.valid && vrsp.done;
	assign in_range = (cmd.addr >= nvm_host_pkg::NVM_LOW_ADDR) && (cmd.addr <= nvm_host_pkg::NVM_HIGH_ADDR);
	assign launch_busy = vrsp.data[nvm_host_pkg::CTRL_LAUNCH_BIT];
	assign write_ok = vrsp.data[nvm_host_pkg::STATUS_OK_BIT];

	// ****************************************
	// Byte write sequencer
	// ****************************************
	always_comb begin
		nxt_host = host_ff;
		unique case (host_ff.phase)
			ST_IDLE: begin
				// A part declared defective takes no further commands until reset
				if (cmd.start && !host_ff.stat.defective) begin
					nxt_host.addr = cmd.addr;
					nxt_host.data = cmd.data;
					nxt_host.stat.retries = 4'h0;
					nxt_host.stat.skipped = 1'b0;
					nxt_host.stat.range_err = 1'b0;
					nxt_host.stat.ok = 1'b0;
					nxt_host.stat.done = 1'b0;
					if (!in_range) begin
						nxt_host.stat.range_err = 1'b1;
						nxt_host.stat.done = 1'b1;
					end else if (cmd.skip_zero && (cmd.data == 8'h00)) begin
						nxt_host.stat.skipped = 1'b1;
						nxt_host.stat.ok = 1'b1;
						nxt_host.stat.done = 1'b1;
					end else if (!host_ff.enabled) begin
						nxt_host.stat.busy = 1'b1;
						nxt_host.phase = ST_ENABLE;
						nxt_host.req = dev_req(1'b1, nvm_host_pkg::DEV_CONFIG_IDX,
							nvm_host_pkg::CFG_ENABLE_MASK);
					end else begin
						nxt_host.stat.busy = 1'b1;
						nxt_host.phase = ST_ADDR;
						nxt_host.req = dev_req(1'b1, nvm_host_pkg::DEV_ADDR_IDX, cmd.addr);
					end
				end
			end
			ST_ENABLE: begin
				if (taken) begin
					nxt_host.enabled = 1'b1;
					nxt_host.phase = ST_ADDR;
					nxt_host.req = dev_req(1'b1, nvm_host_pkg::DEV_ADDR_IDX, host_ff.addr);
				end
			end
			ST_ADDR: begin
				if (taken) begin
					nxt_host.phase = ST_DATA;
					nxt_host.req = dev_req(1'b1, nvm_host_pkg::DEV_VALUE_IDX, host_ff.data);
				end
			end
			ST_DATA: begin
				if (taken) begin
					nxt_host.phase = ST_LAUNCH;
					nxt_host.req = dev_req(1'b1, nvm_host_pkg::DEV_CTRL_IDX,
						nvm_host_pkg::CTRL_LAUNCH_MASK);
				end
			end
			ST_LAUNCH: begin
				if (taken) begin
					nxt_host.phase = ST_POLL;
					nxt_host.req = dev_req(1'b0, nvm_host_pkg::DEV_CTRL_IDX, 8'h00);
				end
			end
			ST_POLL: begin
				// Only reads go out while the launch bit is set, so operands stay put
				if (taken && !launch_busy) begin
					nxt_host.phase = ST_STATUS;
					nxt_host.req = dev_req(1'b0, nvm_host_pkg::DEV_STATUS_IDX, 8'h00);
				end
			end
			ST_STATUS: begin
				if (taken) begin
					if (write_ok) begin
						nxt_host.phase = ST_IDLE;
						nxt_host.req = '0;
						nxt_host.stat.ok = 1'b1;
						nxt_host.stat.done = 1'b1;
						nxt_host.stat.busy = 1'b0;
					end else if (host_ff.stat.retries == nvm_host_pkg::MAX_RETRIES) begin
						nxt_host.phase = ST_IDLE;
						nxt_host.req = '0;
						nxt_host.stat.defective = 1'b1;
						nxt_host.stat.done = 1'b1;
						nxt_host.stat.busy = 1'b0;
					end else begin
						nxt_host.phase = ST_LAUNCH;
						nxt_host.stat.retries = host_ff.stat.retries + 4'h1;
						nxt_host.req = dev_req(1'b1, nvm_host_pkg::DEV_CTRL_IDX,
							nvm_host_pkg::CTRL_LAUNCH_MASK);
					end
				end
			end
			default: begin
				nxt_host = HOST_RESET;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			host_ff <= HOST_RESET;
		end else begin
			host_ff <= nxt_host;
		end
	end

	// Every device access leaves through the vendor request port
	assign vreq = host_ff.req;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	addr_in_window_a: assert property (
		(vreq.valid && vreq.write && vreq.index == nvm_host_pkg::DEV_ADDR_IDX)
		|-> (vreq.value >= nvm_host_pkg::NVM_LOW_ADDR && vreq.value <= nvm_host_pkg::NVM_HIGH_ADDR))
		else $error("address request outside programmable window");

	enable_before_addr_a: assert property (
		$rose(host_ff.phase == ST_ADDR) |-> host_ff.enabled)
		else $error("address loaded before memory enable");

	data_after_addr_a: assert property (
		$rose(host_ff.phase == ST_DATA) |-> $past(host_ff.phase == ST_ADDR) && $past(vrsp.done))
		else $error("data load not preceded by address load");

	launch_value_a: assert property (
		(host_ff.phase == ST_LAUNCH) |-> (vreq.valid && vreq.write && vreq.index == nvm_host_pkg::DEV_CTRL_IDX
		&& vreq.value == nvm_host_pkg::CTRL_LAUNCH_MASK))
		else $error("launch request malformed");

	poll_repeat_a: assert property (
		(host_ff.phase == ST_POLL && vrsp.done && launch_busy)
		|=> (host_ff.phase == ST_POLL && vreq.valid && !vreq.write && vreq.index == nvm_host_pkg::DEV_CTRL_IDX))
		else $error("polling stopped while launch bit set");

	status_after_clear_a: assert property (
		(host_ff.phase == ST_POLL && vrsp.done && !launch_busy)
		|=> (vreq.valid && !vreq.write && vreq.index == nvm_host_pkg::DEV_STATUS_IDX))
		else $error("status not read after launch cleared");

	success_finish_a: assert property (
		(host_ff.phase == ST_STATUS && vrsp.done && write_ok)
		|=> (host_ff.phase == ST_IDLE && host_ff.stat.ok && host_ff.stat.done && !host_ff.stat.busy
		&& host_ff.enabled && !vreq.valid))
		else $error("successful write not completed");

	retry_relaunch_a: assert property (
		(host_ff.phase == ST_STATUS && vrsp.done && !write_ok && host_ff.stat.retries != nvm_host_pkg::MAX_RETRIES)
		|=> (host_ff.phase == ST_LAUNCH && host_ff.stat.retries == $past(host_ff.stat.retries) + 4'h1))
		else $error("failed write not relaunched");

	defect_stop_a: assert property (
		(host_ff.phase == ST_STATUS && vrsp.done && !write_ok && host_ff.stat.retries == nvm_host_pkg::MAX_RETRIES)
		|=> (host_ff.stat.defective && host_ff.phase == ST_IDLE) ##1 (host_ff.phase == ST_IDLE))
		else $error("defective part not stopped");

	request_hold_a: assert property (
		(vreq.valid && !vrsp.done) |=> $stable(vreq))
		else $error("request changed before it was answered");

	operand_freeze_a: assert property (
		(host_ff.stat.busy && host_ff.phase != ST_ENABLE) |=> $stable(host_ff.addr) && $stable(host_ff.data))
		else $error("operands changed during a write");

	skip_zero_a: assert property (
		(host_ff.phase == ST_IDLE && cmd.start && !host_ff.stat.defective && in_range && cmd.skip_zero
		&& cmd.data == 8'h00) |=> (host_ff.stat.skipped && host_ff.phase == ST_IDLE && !vreq.valid))
		else $error("zero value not skipped");

	// ****************************************
	// Request shape and status checks
	// ****************************************
	idle_quiet_a: assert property (
		(host_ff.phase == ST_IDLE) |-> !vreq.valid)
		else $error("request pending while idle");

	enable_request_a: assert property (
		(host_ff.phase == ST_ENABLE) |-> (vreq.valid && vreq.write
		&& vreq.index == nvm_host_pkg::DEV_CONFIG_IDX && vreq.value == nvm_host_pkg::CFG_ENABLE_MASK))
		else $error("enable request malformed");

	addr_request_a: assert property (
		(host_ff.phase == ST_ADDR) |-> (vreq.valid && vreq.write
		&& vreq.index == nvm_host_pkg::DEV_ADDR_IDX && vreq.value == host_ff.addr))
		else $error("address request malformed");

	data_request_a: assert property (
		(host_ff.phase == ST_DATA) |-> (vreq.valid && vreq.write
		&& vreq.index == nvm_host_pkg::DEV_VALUE_IDX && vreq.value == host_ff.data))
		else $error("data request malformed");

	poll_request_a: assert property (
		(host_ff.phase == ST_POLL)
		|-> (vreq.valid && !vreq.write && vreq.index == nvm_host_pkg::DEV_CTRL_IDX))
		else $error("poll request malformed");

	status_request_a: assert property (
		(host_ff.phase == ST_STATUS)
		|-> (vreq.valid && !vreq.write && vreq.index == nvm_host_pkg::DEV_STATUS_IDX))
		else $error("status request malformed");

	// Software sees busy exactly while device traffic is still owed
	busy_tracks_phase_a: assert property (
		host_ff.stat.busy == (host_ff.phase != ST_IDLE))
		else $error("busy flag disagrees with sequencer");

	done_not_busy_a: assert property (
		host_ff.stat.done |-> !host_ff.stat.busy)
		else $error("done reported while still busy");

	// Enable is sent once per reset, later bytes start at the address load
	single_enable_a: assert property (
		(host_ff.enabled && vreq.valid) |-> (vreq.index != nvm_host_pkg::DEV_CONFIG_IDX))
		else $error("memory enable sent twice");

	start_accept_a: assert property (
		(host_ff.phase == ST_IDLE && cmd.start && !host_ff.stat.defective && in_range
		&& !(cmd.skip_zero && cmd.data == 8'h00)) |=> (host_ff.stat.busy && vreq.valid && vreq.write))
		else $error("accepted start did not begin a write");

	launch_source_a: assert property (
		$rose(host_ff.phase == ST_LAUNCH)
		|-> ($past(host_ff.phase == ST_DATA) || $past(host_ff.phase == ST_STATUS)))
		else $error("launch without loaded operands");

	range_refuse_a: assert property (
		(host_ff.phase == ST_IDLE && cmd.start && !host_ff.stat.defective && !in_range)
		|=> (host_ff.stat.range_err && host_ff.stat.done && host_ff.phase == ST_IDLE && !vreq.valid))
		else $error("out of window address not refused");

	defect_sticky_a: assert property (
		host_ff.stat.defective |=> host_ff.stat.defective)
		else $error("defective flag lost");

	// Only a reset lifts the defective verdict
	defect_refuse_a: assert property (
		(host_ff.phase == ST_IDLE && host_ff.stat.defective) |=> (host_ff.phase == ST_IDLE && !vreq.valid))
		else $error("defective part took a command");

	retry_bound_a: assert property (
		host_ff.stat.retries <= nvm_host_pkg::MAX_RETRIES)
		else $error("retry count beyond limit");

endmodule

// ===== sim/nvm_dev_model.sv
`timescale 1ns/10ps

module nvm_dev_model (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rstn,
	// Requests from the host
	input  wire nvm_host_pkg::vreq_type vreq,
	output nvm_host_pkg::vrsp_type      vrsp,
	// Knobs and observations
	input  wire logic [3:0]             lat,
	input  wire logic [3:0]             polls,
	input  wire logic [3:0]             fails,
	output logic [7:0]                  n_enable,
	output logic [7:0]                  n_launch,
	output logic [7:0]                  viol,
	output logic [15:0]                 last_prog
);
	logic [7:0] cfg_ff, adr_ff, val_ff, rd;
	logic [3:0] wt_ff, pl_ff, fl_ff;
	logic [1:0] stage_ff;
	logic       busy_ff, ok_ff, w, c, pass;

	// ****
	// Answer; an idle data line shows the inverse so nothing stale passes
	// ****
	always_comb begin
		case (vreq.index)
			nvm_host_pkg::DEV_CONFIG_IDX: rd = cfg_ff;
			nvm_host_pkg::DEV_ADDR_IDX:   rd = adr_ff;
			nvm_host_pkg::DEV_VALUE_IDX:  rd = val_ff;
			nvm_host_pkg::DEV_CTRL_IDX:   rd = {7'h00, busy_ff && pl_ff != 4'h0};
			nvm_host_pkg::DEV_STATUS_IDX: rd = {7'h00, ok_ff};
			default:                      rd = 8'h00;
		endcase
		vrsp.done = vreq.valid && wt_ff == lat;
		vrsp.data = vrsp.done ? rd : ~rd;
	end
	assign w = vrsp.done && vreq.write;
	assign c = vreq.index == nvm_host_pkg::DEV_CTRL_IDX;
	assign pass = fl_ff >= fails;

	// ****
	// Registers and host-side checks
	// ****
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			{cfg_ff, adr_ff, val_ff, wt_ff, pl_ff, fl_ff, stage_ff, busy_ff, ok_ff} <= '0;
			{n_enable, n_launch, viol, last_prog} <= '0;
		end else begin
			wt_ff <= (vreq.valid && !vrsp.done) ? wt_ff + 4'h1 : 4'h0;
			if (w && busy_ff && !c) viol <= viol + 8'h01;
			if (w && vreq.index == nvm_host_pkg::DEV_CONFIG_IDX) begin
				cfg_ff <= vreq.value;
				n_enable <= n_enable + 8'h01;
			end
			if (w && vreq.index == nvm_host_pkg::DEV_ADDR_IDX) begin
				adr_ff <= vreq.value;
				stage_ff <= 2'h1;
			end
			if (w && vreq.index == nvm_host_pkg::DEV_VALUE_IDX) begin
				val_ff <= vreq.value;
				stage_ff <= 2'h2;
				if (stage_ff != 2'h1) viol <= viol + 8'h01;
			end
			if (w && c && vreq.value[0]) begin
				busy_ff <= 1'b1;
				pl_ff <= polls;
				n_launch <= n_launch + 8'h01;
				if (!cfg_ff[0] || stage_ff != 2'h2 || fl_ff == 4'hB || adr_ff < nvm_host_pkg::NVM_LOW_ADDR ||
					adr_ff > nvm_host_pkg::NVM_HIGH_ADDR) viol <= viol + 8'h01;
			end
			if (vrsp.done && !vreq.write && c && busy_ff) begin
				pl_ff <= pl_ff - 4'h1;
				if (pl_ff == 4'h0) begin
					busy_ff <= 1'b0;
					ok_ff <= pass;
					fl_ff <= pass ? 4'h0 : fl_ff + 4'h1;
					if (pass) last_prog <= {adr_ff, val_ff};
					if (pass) stage_ff <= 2'h0;
				end
			end
		end
	end
endmodule

// ===== sim/test_nvm_write_host.sv
`timescale 1ns/10ps

module test_nvm_write_host;
	logic                      core_clk;
	logic                      rstn;
	nvm_host_pkg::apb_req_type apb_req;
	nvm_host_pkg::apb_rsp_type apb_rsp;
	nvm_host_pkg::vreq_type    vreq;
	nvm_host_pkg::vrsp_type    vrsp;
	logic [3:0]                lat, polls, fails;
	logic [7:0]                n_enable, n_launch, viol;
	logic [15:0]               last_prog;
	logic [31:0]               rd;
	logic                      err;
	int                        n_errors = 0;
	int                        checked = 0;

	nvm_write_host nvm_write_host_i (.core_clk(core_clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.vreq(vreq), .vrsp(vrsp));
	nvm_dev_model nvm_dev_model_i (.core_clk(core_clk), .rstn(rstn), .vreq(vreq), .vrsp(vrsp), .lat(lat),
		.polls(polls), .fails(fails), .n_enable(n_enable), .n_launch(n_launch), .viol(viol), .last_prog(last_prog));

	// ****
	// Shared tasks
	// ****
	task automatic stop_test();
		$display("n_errors %0d checked %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	// Busy rises two edges after the start write; polling sooner could read a stale idle
	// A busy flag that never drops is caught by the watchdog
	task automatic wait_idle();
		repeat (2) @(posedge core_clk);
		do begin
			apb(1'b0, nvm_host_pkg::REG_STATUS, 32'h00000000);
		end while (rd[0] !== 1'b0);
	endtask

	task automatic launch(input logic [7:0] a, input logic [7:0] d, input logic [31:0] c);
		apb(1'b1, nvm_host_pkg::REG_ADDR, 32'(a));
		apb(1'b1, nvm_host_pkg::REG_DATA, 32'(d));
		apb(1'b1, nvm_host_pkg::REG_CTRL, c);
		wait_idle();
		cmp(32'(viol), 32'h00000000);
	endtask

	// ****
	// Scenarios
	// ****
	task automatic reset_values();
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 12'(i * 4), 32'h00000000);
			cmp(rd, 32'h00000000);
			cmp(32'(err), 32'(i == 4));
		end
		cmp(32'(vreq.valid), 32'h00000000);
	endtask

	task automatic first_byte();
		launch(8'h80, 8'h5A, 32'h00000001);
		cmp(rd, 32'h00000006);
		cmp(32'(last_prog), 32'h0000805A);
		cmp(32'(n_enable), 32'h00000001);
	endtask

	task automatic slow_byte_locked();
		lat <= 4'h3;
		polls <= 4'h4;
		apb(1'b1, nvm_host_pkg::REG_ADDR, 32'h000000FE);
		apb(1'b1, nvm_host_pkg::REG_DATA, 32'h000000C3);
		apb(1'b1, nvm_host_pkg::REG_CTRL, 32'h00000001);
		apb(1'b1, nvm_host_pkg::REG_ADDR, 32'h00000011);
		wait_idle();
		cmp(rd, 32'h00000006);
		cmp(32'(last_prog), 32'h0000FEC3);
		cmp(32'(n_enable), 32'h00000001);
		apb(1'b0, nvm_host_pkg::REG_ADDR, 32'h00000000);
		cmp(rd, 32'h000000FE);
	endtask

	task automatic range_and_skip();
		lat <= 4'h1;
		launch(8'h7F, 8'h33, 32'h00000001);
		cmp(rd, 32'h00000012);
		launch(8'h90, 8'h00, 32'h00000003);
		cmp(rd, 32'h00000026);
		apb(1'b0, nvm_host_pkg::REG_CTRL, 32'h00000000);
		cmp(rd, 32'h00000002);
		launch(8'h91, 8'h00, 32'h00000001);
		cmp(rd, 32'h00000006);
		cmp(32'(last_prog), 32'h00009100);
		cmp(32'(n_launch), 32'h00000003);
	endtask

	task automatic retry_then_ok();
		fails <= 4'h3;
		polls <= 4'h0;
		launch(8'hA0, 8'h77, 32'h00000001);
		cmp(rd, 32'h000000C6);
		cmp(32'(n_launch), 32'h00000007);
	endtask

	task automatic defective_and_reset();
		fails <= 4'hF;
		launch(8'hA1, 8'h01, 32'h00000001);
		cmp(rd, 32'h0000028A);
		cmp(32'(n_launch), 32'h00000012);
		launch(8'hA2, 8'h02, 32'h00000001);
		cmp(rd, 32'h0000028A);
		cmp(32'(n_launch), 32'h00000012);
		rstn <= 1'b0;
		fails <= 4'h0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		apb(1'b0, nvm_host_pkg::REG_STATUS, 32'h00000000);
		cmp(rd, 32'h00000000);
		launch(8'hB0, 8'h44, 32'h00000001);
		cmp(rd, 32'h00000006);
		cmp(32'(n_enable), 32'h00000001);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// A few hundred cycles are expected; fifty thousand means a hang
	initial begin
		#200000;
		n_errors++;
		stop_test();
	end

	initial begin
		apb_req = '0;
		rstn = 1'b0;
		lat = 4'h0;
		polls = 4'h2;
		fails = 4'h0;
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		reset_values();
		first_byte();
		slow_byte_locked();
		range_and_skip();
		retry_then_ok();
		defective_and_reset();
		stop_test();
	end
endmodule
